/* File: hdl/csc_defs.svh */
// offsets, field positions, reset values and counts of the calendar second counter
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_ADDR_W          8
`define CSC_ADDR_TRIM       8'h00
`define CSC_ADDR_COUNT      8'h04
`define CSC_ADDR_LOAD       8'h08
`define CSC_ADDR_CTRL       8'h0c
`define CSC_ADDR_IRQ_EN     8'h10
`define CSC_ADDR_FLAGS      8'h14
`define CSC_ADDR_FLAG_CLR   8'h18

`define CSC_CTRL_PRESET_BIT 0

`define CSC_SEC_LSB         0
`define CSC_MIN_LSB         8
`define CSC_HOUR_LSB        16
`define CSC_DAY_LSB         21

`define CSC_TRIM_RESET      10'h2cf
`define CSC_TERM_HIGH       11'h4c4
`define CSC_REF_DIV         8
`define CSC_REF_HZ          10000000
`define CSC_MCLK_HZ         100000000

`define CSC_SEC_LAST        6'h3b
`define CSC_MIN_LAST        6'h3b
`define CSC_HOUR_LAST       5'h17
`define CSC_INT10_LEN       6'h0a
`define CSC_INT30_LEN       6'h1e
`define CSC_INT60_LEN       6'h3c

`endif

/* File: hdl/csc_pkg.sv */
// types and field packing of the calendar second counter
`default_nettype none
`include "csc_defs.svh"
package csc_pkg;
  typedef struct packed {
    logic [10:0] day;
    logic [4:0]  hour;
    logic [5:0]  min;
    logic [5:0]  sec;
  } csc_cal_type;

  typedef logic [3:0] csc_flags_type;

  function automatic logic [31:0] csc_pack(input csc_cal_type c);
    logic [31:0] w;
    w = 32'h0;
    w[`CSC_SEC_LSB +: 6]  = c.sec;
    w[`CSC_MIN_LSB +: 6]  = c.min;
    w[`CSC_HOUR_LSB +: 5] = c.hour;
    w[`CSC_DAY_LSB +: 11] = c.day;
    return w;
  endfunction : csc_pack

  function automatic csc_cal_type csc_unpack(input logic [31:0] w);
    csc_cal_type c;
    c.sec  = w[`CSC_SEC_LSB +: 6];
    c.min  = w[`CSC_MIN_LSB +: 6];
    c.hour = w[`CSC_HOUR_LSB +: 5];
    c.day  = w[`CSC_DAY_LSB +: 11];
    return c;
  endfunction : csc_unpack
endpackage : csc_pkg
`default_nettype wire

/* File: hdl/csc_sync.sv */
// two flip-flop level synchroniser
`default_nettype none
module csc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_q
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("csc_sync width must be at least one");
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule : csc_sync
`default_nettype wire

/* File: hdl/csc_tick_gen.sv */
// reference edge divider and trimmable one-second prescaler
`default_nettype none
`include "csc_defs.svh"
module csc_tick_gen
  import csc_pkg::*;
#(
  parameter int          REF_DIV   = `CSC_REF_DIV,
  parameter logic [10:0] TERM_HIGH = `CSC_TERM_HIGH
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       ref_level,
  input  wire logic [9:0] trim,
  output var  logic       sec_tick_q
);
  logic       ref_prev_q;
  logic [7:0] div_q;
  logic       slow_en_q;
  logic [20:0] pre_q;
  logic       ref_rise;
  logic [20:0] term;

  initial begin
    if (REF_DIV < 2 || REF_DIV > 256) $error("csc_tick_gen REF_DIV out of range");
  end

  assign ref_rise = ref_level & ~ref_prev_q;
  assign term     = {TERM_HIGH, trim};

  always_ff @(posedge mclk) begin
    if (!reset_n) ref_prev_q <= 1'b0;
    else          ref_prev_q <= ref_level;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_q     <= 8'h00;
      slow_en_q <= 1'b0;
    end else begin
      slow_en_q <= 1'b0;
      if (ref_rise) begin
        if (div_q == 8'(REF_DIV - 1)) begin
          div_q     <= 8'h00;
          slow_en_q <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end
    end
  end

  // >= keeps the counter from running away when trim is lowered mid-second
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pre_q      <= 21'h0;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      if (slow_en_q) begin
        if (pre_q >= term) begin
          pre_q      <= 21'h0;
          sec_tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 21'h1;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  tick_cause_a: assert property (sec_tick_q |-> $past(slow_en_q) && pre_q == 21'h0)
    else $error("second tick without a terminal count");
  slow_rate_a: assert property (slow_en_q |-> $past(ref_rise) && div_q == 8'h00)
    else $error("slow enable not on the last reference edge");
endmodule : csc_tick_gen
`default_nettype wire

/* File: hdl/csc_top.sv */
// calendar second counter: registers, calendar, interval flags and interrupt
// Operation
// - divide reference by eight first
// - terminal count 0x1312cf gives one second
// - only low ten bits come from trim
// - trim resets 0x2cf, accepts full range
// - one trim step about 0.8 ppm
// - count seconds, minutes, hours, days per tick
// - day field is eleven bits wide
// - preset enable high then low loads count
// - flags every 1, 10, 30, 60 seconds
// - flags set regardless of enables
// - reading flags clears returned flags
// - enabled set flag raises interrupt
`default_nettype none
`include "csc_defs.svh"
module csc_top
  import csc_pkg::*;
#(
  parameter int          REF_DIV   = `CSC_REF_DIV,
  parameter logic [10:0] TERM_HIGH = `CSC_TERM_HIGH
) (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   ref_clk_in,
  input  wire logic [`CSC_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wr_data,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output var  logic [31:0]            rd_data_q,
  output var  logic                   irq_q
);
  logic [9:0]    trim_q;
  csc_cal_type   cal_q;
  csc_cal_type   cal_d;
  logic [31:0]   load_val_q;
  logic          preset_en_q;
  logic          preset_prev_q;
  csc_flags_type irq_en_q;
  csc_flags_type flags_q;
  csc_flags_type flags_d;
  csc_flags_type flag_set;
  csc_flags_type flag_clr;
  logic          ref_sync;
  logic          sec_tick;
  logic          load_pulse;
  logic [5:0]    int_cnt_q [3];

  initial begin
    if (`CSC_MCLK_HZ < 4 * `CSC_REF_HZ) $error("processor clock too slow to sample reference");
  end

  function automatic logic hit(input logic [`CSC_ADDR_W-1:0] a,
                               input logic [`CSC_ADDR_W-1:0] reg_addr);
    return a == reg_addr;
  endfunction : hit

  function automatic logic [5:0] interval_len(input int idx);
    case (idx)
      0:       return `CSC_INT10_LEN;
      1:       return `CSC_INT30_LEN;
      default: return `CSC_INT60_LEN;
    endcase
  endfunction : interval_len

  // reference is a pin from another clock: two flops before the edge detector
  csc_sync #(
    .WIDTH (1)
  ) u_ref_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (ref_clk_in),
    .sync_q   (ref_sync)
  );

  csc_tick_gen #(
    .REF_DIV   (REF_DIV),
    .TERM_HIGH (TERM_HIGH)
  ) u_tick_gen (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .ref_level  (ref_sync),
    .trim       (trim_q),
    .sec_tick_q (sec_tick)
  );

  // trim register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      trim_q <= `CSC_TRIM_RESET;
    end else if (wr_en && hit(addr, `CSC_ADDR_TRIM)) begin
      trim_q <= wr_data[9:0];
    end
  end

  // preset value and control
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      load_val_q <= 32'h0;
    end else if (wr_en && hit(addr, `CSC_ADDR_LOAD)) begin
      load_val_q <= csc_pack(csc_unpack(wr_data));
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      preset_en_q   <= 1'b0;
      preset_prev_q <= 1'b0;
    end else begin
      preset_prev_q <= preset_en_q;
      if (wr_en && hit(addr, `CSC_ADDR_CTRL)) begin
        preset_en_q <= wr_data[`CSC_CTRL_PRESET_BIT];
      end
    end
  end

  // the load happens on the falling side so a held-high enable loads once
  assign load_pulse = preset_prev_q & ~preset_en_q;

  // calendar next value; a load wins over a tick in the same cycle
  always_comb begin
    cal_d = cal_q;
    if (load_pulse) begin
      cal_d = csc_unpack(load_val_q);
    end else if (sec_tick) begin
      if (cal_q.sec >= `CSC_SEC_LAST) begin
        cal_d.sec = 6'h00;
        if (cal_q.min >= `CSC_MIN_LAST) begin
          cal_d.min = 6'h00;
          if (cal_q.hour >= `CSC_HOUR_LAST) begin
            cal_d.hour = 5'h00;
            cal_d.day  = cal_q.day + 11'h001;
          end else begin
            cal_d.hour = cal_q.hour + 5'h01;
          end
        end else begin
          cal_d.min = cal_q.min + 6'h01;
        end
      end else begin
        cal_d.sec = cal_q.sec + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) cal_q <= '0;
    else          cal_q <= cal_d;
  end

  // interval counters of elapsed ticks, free of the calendar so a preset
  // does not shift the interval flags
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_interval
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          int_cnt_q[g] <= 6'h00;
        end else if (sec_tick) begin
          if (int_cnt_q[g] == interval_len(g) - 6'h01) int_cnt_q[g] <= 6'h00;
          else                                         int_cnt_q[g] <= int_cnt_q[g] + 6'h01;
        end
      end
      assign flag_set[g+1] = sec_tick && (int_cnt_q[g] == interval_len(g) - 6'h01);
      // a counter past its length would not raise its flag again until it wrapped past 63
      interval_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
                                         int_cnt_q[g] < interval_len(g))
        else $error("interval counter out of range");
    end
  endgenerate

  assign flag_set[0] = sec_tick;

  // read clears only the bits it returned; a set in the same cycle survives
  always_comb begin
    flag_clr = 4'h0;
    if (rd_en && hit(addr, `CSC_ADDR_FLAGS)) begin
      flag_clr = flags_q;
    end
    if (wr_en && hit(addr, `CSC_ADDR_FLAG_CLR)) begin
      flag_clr = flag_clr | wr_data[3:0];
    end
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) flags_q <= 4'h0;
    else          flags_q <= flags_d;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_en_q <= 4'h0;
    end else if (wr_en && hit(addr, `CSC_ADDR_IRQ_EN)) begin
      irq_en_q <= wr_data[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) irq_q <= 1'b0;
    else          irq_q <= |(flags_q & irq_en_q);
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_data_q <= 32'h0;
    end else if (rd_en) begin
      unique case (addr)
        `CSC_ADDR_TRIM:   rd_data_q <= {22'h0, trim_q};
        `CSC_ADDR_COUNT:  rd_data_q <= csc_pack(cal_q);
        `CSC_ADDR_LOAD:   rd_data_q <= load_val_q;
        `CSC_ADDR_CTRL:   rd_data_q <= {31'h0, preset_en_q};
        `CSC_ADDR_IRQ_EN: rd_data_q <= {28'h0, irq_en_q};
        `CSC_ADDR_FLAGS:  rd_data_q <= {28'h0, flags_q};
        default:          rd_data_q <= 32'h0;
      endcase
    end else begin
      rd_data_q <= 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sec_advance_a: assert property (sec_tick && !load_pulse && cal_q.sec < `CSC_SEC_LAST
                                  |=> cal_q.sec == $past(cal_q.sec) + 6'h01)
    else $error("seconds did not advance on tick");
  sec_rollover_a: assert property (sec_tick && !load_pulse && cal_q.sec == `CSC_SEC_LAST
                                   && cal_q.min < `CSC_MIN_LAST
                                   |=> cal_q.sec == 6'h00
                                       && cal_q.min == $past(cal_q.min) + 6'h01)
    else $error("seconds rollover did not carry into minutes");
  hour_rollover_a: assert property (sec_tick && !load_pulse && cal_q.sec == `CSC_SEC_LAST
                                    && cal_q.min == `CSC_MIN_LAST
                                    && cal_q.hour == `CSC_HOUR_LAST
                                    |=> cal_q.hour == 5'h00
                                        && cal_q.day == $past(cal_q.day) + 11'h001)
    else $error("hours rollover did not carry into days");
  preset_load_a: assert property ($fell(preset_en_q) |=> csc_pack(cal_q) == $past(load_val_q, 2)
                                                        || $past(wr_en))
    else $error("preset value not copied into count");
  flag_one_a: assert property (sec_tick |=> flags_q[0])
    else $error("one second flag not set by tick");
  flag_nest_a: assert property (flag_set[3] |-> flag_set[2] && flag_set[1] && flag_set[0])
    else $error("sixty second flag without shorter intervals");
  read_clear_a: assert property (rd_en && hit(addr, `CSC_ADDR_FLAGS) && !sec_tick
                                 |=> flags_q == 4'h0 && rd_data_q == {28'h0, $past(flags_q)})
    else $error("flag read did not return and clear flags");
  irq_level_a: assert property (|(flags_q & irq_en_q) |=> irq_q)
    else $error("enabled flag did not raise interrupt");
  irq_quiet_a: assert property (!(|(flags_q & irq_en_q)) |=> !irq_q)
    else $error("interrupt without an enabled flag");
  trim_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_TRIM)
                                |=> rd_data_q == {22'h0, $past(trim_q)})
    else $error("trim read back wrong");


  // register writes land at the strobe edge, all ten trim bits included
  trim_write_a: assert property (wr_en && hit(addr, `CSC_ADDR_TRIM)
                                 |=> trim_q == $past(wr_data[9:0]))
    else $error("trim write not stored");
  trim_hold_a: assert property (!(wr_en && hit(addr, `CSC_ADDR_TRIM))
                                |=> trim_q == $past(trim_q))
    else $error("trim changed without a write");
  irq_en_write_a: assert property (wr_en && hit(addr, `CSC_ADDR_IRQ_EN)
                                   |=> irq_en_q == $past(wr_data[3:0]))
    else $error("interrupt enable write not stored");
  irq_en_hold_a: assert property (!(wr_en && hit(addr, `CSC_ADDR_IRQ_EN))
                                  |=> irq_en_q == $past(irq_en_q))
    else $error("interrupt enable changed without a write");
  load_hold_a: assert property (!(wr_en && hit(addr, `CSC_ADDR_LOAD))
                                |=> load_val_q == $past(load_val_q))
    else $error("preset value changed without a write");
  preset_hold_a: assert property (!(wr_en && hit(addr, `CSC_ADDR_CTRL))
                                  |=> preset_en_q == $past(preset_en_q))
    else $error("preset enable changed without a write");

  // the count only moves on a tick or a load; bus writes to it are ignored
  count_hold_a: assert property (!sec_tick && !load_pulse |=> cal_q == $past(cal_q))
    else $error("count moved without tick or load");
  min_rollover_a: assert property (sec_tick && !load_pulse && cal_q.sec == `CSC_SEC_LAST
                                   && cal_q.min == `CSC_MIN_LAST
                                   && cal_q.hour < `CSC_HOUR_LAST
                                   |=> cal_q.min == 6'h00
                                       && cal_q.hour == $past(cal_q.hour) + 5'h01)
    else $error("minutes rollover did not carry into hours");
  day_keep_a: assert property (sec_tick && !load_pulse && cal_q.hour < `CSC_HOUR_LAST
                               |=> cal_q.day == $past(cal_q.day))
    else $error("day moved before hours rolled over");
  load_value_a: assert property (load_pulse |=> cal_q == csc_unpack($past(load_val_q)))
    else $error("load did not take the preset value");

  // flags are sticky until a read or a clear write takes them away
  flag_sticky_a: assert property (!(rd_en && hit(addr, `CSC_ADDR_FLAGS))
                                  && !(wr_en && hit(addr, `CSC_ADDR_FLAG_CLR))
                                  |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("status flag lost without a read or clear");
  flag_clear_a: assert property (wr_en && hit(addr, `CSC_ADDR_FLAG_CLR) && !sec_tick
                                 |=> (flags_q & $past(wr_data[3:0])) == 4'h0)
    else $error("flag clear write left flags set");
  flag_cause_a: assert property (!sec_tick |=> (flags_q & ~$past(flags_q)) == 4'h0)
    else $error("flag set without a tick");
  flag_ten_a: assert property (flag_set[1] |=> flags_q[1])
    else $error("ten second flag not set");
  flag_thirty_a: assert property (flag_set[2] |=> flags_q[2])
    else $error("thirty second flag not set");
  flag_sixty_a: assert property (flag_set[3] |=> flags_q[3])
    else $error("sixty second flag not set");

  // read data are zero outside the cycle after a read strobe
  rd_idle_a: assert property (!rd_en |=> rd_data_q == 32'h0)
    else $error("read data not zero while idle");
  count_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_COUNT)
                                 |=> rd_data_q == csc_pack($past(cal_q)))
    else $error("count read back wrong");
  irq_en_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_IRQ_EN)
                                  |=> rd_data_q == {28'h0, $past(irq_en_q)})
    else $error("enable read back wrong");
  load_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_LOAD)
                                |=> rd_data_q == $past(load_val_q))
    else $error("preset value read back wrong");
  ctrl_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_CTRL)
                                |=> rd_data_q == {31'h0, $past(preset_en_q)})
    else $error("control read back wrong");
  clr_read_a: assert property (rd_en && hit(addr, `CSC_ADDR_FLAG_CLR) |=> rd_data_q == 32'h0)
    else $error("write-only clear register read not zero");

  load_seen_c: cover property (load_pulse);
  day_wrap_c: cover property (sec_tick && cal_q.day == 11'h7ff && cal_q.hour == `CSC_HOUR_LAST);
  minute_roll_c: cover property (sec_tick && cal_q.sec == `CSC_SEC_LAST);
  irq_rise_c: cover property ($rose(irq_q));
  flag60_c: cover property (flag_set[3]);
endmodule : csc_top
`default_nettype wire

/* File: verif/csc_top_tb_top.sv */
// self-checking bench for the calendar second counter
`default_nettype none
`include "csc_defs.svh"
module csc_top_tb_top
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   mclk;
  logic                   reset_n;
  logic                   ref_clk_in;
  logic [`CSC_ADDR_W-1:0] addr;
  logic [31:0]            wr_data;
  logic                   wr_en;
  logic                   rd_en;
  logic [31:0]            rd_data_q;
  logic                   irq_q;
  int                     num_errors;
  int                     n_compared;
  logic [31:0]            exp_q[$];
  logic                   rd_pend_q = 1'b0;
  integer                 seed;
  csc_cal_type            cal;
  logic [3:0]             en;
  logic [3:0]             expf;

  // short second: two reference edges per slow enable, terminal count equals trim
  csc_top #(.REF_DIV(2), .TERM_HIGH(11'h000)) u_dut (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .ref_clk_in (ref_clk_in),
    .addr       (addr),
    .wr_data    (wr_data),
    .wr_en      (wr_en),
    .rd_en      (rd_en),
    .rd_data_q  (rd_data_q),
    .irq_q      (irq_q)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr  <= a;
    exp_q.push_back(exp);
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask : rd

  // reference pin runs only on request, so the bench knows every tick exactly
  task automatic ref_edges(input int n);
    repeat (n) begin
      @(posedge mclk);
      ref_clk_in <= 1'b1;
      repeat (3) @(posedge mclk);
      ref_clk_in <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask : ref_edges

  function automatic logic [31:0] pk(input csc_cal_type c);
    return {c.day, c.hour, 2'h0, c.min, 2'h0, c.sec};
  endfunction : pk

  function automatic csc_cal_type step(input csc_cal_type c);
    if (c.sec != 6'h3b) begin
      c.sec = c.sec + 6'h01;
    end else begin
      c.sec = 6'h00;
      if (c.min != 6'h3b) begin
        c.min = c.min + 6'h01;
      end else begin
        c.min = 6'h00;
        if (c.hour != 5'h17) begin
          c.hour = c.hour + 5'h01;
        end else begin
          c.hour = 5'h00;
          c.day  = c.day + 11'h001;
        end
      end
    end
    return c;
  endfunction : step

  // read data stand only in the cycle after the strobe edge
  always @(posedge mclk) begin
    if (rd_pend_q) begin
      check(rd_data_q, exp_q.pop_front());
    end
    rd_pend_q <= rd_en;
  end

  initial begin
    repeat (50000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  initial begin
    reset_n    = 1'b0;
    ref_clk_in = 1'b0;
    addr       = 8'h00;
    wr_data    = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    num_errors = 0;
    n_compared = 0;
    seed       = 1714;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;

    rd(`CSC_ADDR_TRIM, 32'h0000_02cf);
    rd(`CSC_ADDR_COUNT, 32'h0);
    rd(`CSC_ADDR_IRQ_EN, 32'h0);
    rd(`CSC_ADDR_FLAGS, 32'h0);
    rd(8'h1c, 32'h0);
    wr(`CSC_ADDR_TRIM, 32'hffff_ffff);
    rd(`CSC_ADDR_TRIM, 32'h0000_03ff);
    wr(`CSC_ADDR_TRIM, 32'h0000_0003);
    rd(`CSC_ADDR_TRIM, 32'h0000_0003);
    $display("test registers done");

    cal = '{day: 11'h7ff, hour: 5'h17, min: 6'h3b, sec: 6'h3a};
    wr(`CSC_ADDR_LOAD, pk(cal));
    rd(`CSC_ADDR_LOAD, pk(cal));
    wr(`CSC_ADDR_CTRL, 32'h1);
    rd(`CSC_ADDR_COUNT, 32'h0);
    wr(`CSC_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    rd(`CSC_ADDR_COUNT, pk(cal));
    wr(`CSC_ADDR_COUNT, 32'hffff_ffff);
    rd(`CSC_ADDR_COUNT, pk(cal));
    $display("test preset done");

    for (int i = 1; i <= 60; i++) begin
      en = 4'($random(seed));
      wr(`CSC_ADDR_IRQ_EN, {28'h0, en});
      if (i == 1) begin
        // one edge short of a second must not tick
        ref_edges(7);
        repeat (8) @(posedge mclk);
        rd(`CSC_ADDR_FLAGS, 32'h0);
        ref_edges(1);
      end else begin
        ref_edges(8);
      end
      repeat (8) @(posedge mclk);
      expf = {i % 60 == 0, i % 30 == 0, i % 10 == 0, 1'b1};
      check(32'(irq_q), 32'(|(expf & en)));
      if (i == 5) begin
        wr(`CSC_ADDR_FLAG_CLR, 32'hf);
        repeat (2) @(posedge mclk);
        check(32'(irq_q), 32'h0);
        expf = 4'h0;
      end
      cal = step(cal);
      rd(`CSC_ADDR_FLAGS, {28'h0, expf});
      rd(`CSC_ADDR_FLAGS, 32'h0);
      rd(`CSC_ADDR_COUNT, pk(cal));
    end
    $display("test seconds done");
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule : csc_top_tb_top
`default_nettype wire
